// *** dopc_gain_ramp.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dopc_regs.vh"
// ==========================================================
// per-channel gain ramp: applies a target at once or steps toward it
module dopc_gain_ramp (
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       sample_tick,
  input  wire       ramp_on,
  input  wire       fine_on,
  input  wire [7:0] target,
  output reg  [7:0] gain,
  output reg  [1:0] fine_phase
);
  wire fine_mode;
  wire step_now;
  // subrange only matters while ramping
  assign fine_mode = ramp_on & fine_on;
  // in fine mode a coarse step is taken only after all substeps
  assign step_now  = sample_tick & (~fine_mode | (fine_phase == 2'h3));

  // ==========================================================
  // gain tracking
  always @(posedge ref_clk) begin
    if (!rstn) begin
      gain       <= `DOPC_GAIN_RESET;
      fine_phase <= 2'h0;
    end else if (!ramp_on) begin
      gain       <= target;
      fine_phase <= 2'h0;
    end else if (gain == target) begin
      fine_phase <= 2'h0;
    end else begin
      if (sample_tick && fine_mode)
        fine_phase <= fine_phase + 2'h1;
      if (step_now) begin
        if (gain < target)
          gain <= gain + 8'h01;
        else
          gain <= gain - 8'h01;
      end
    end
  end
endmodule // dopc_gain_ramp
`default_nettype wire

// *** dopc_out_path.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dopc_regs.vh"
// ==========================================================
// left and right playback path control registers
// gain targets and coefficient bytes share the same strobes
// a write or a read is taken on one ref_clk edge
module dopc_out_path (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         left_path_enable,
  output reg         right_path_enable,
  output reg         left_path_mute,
  output reg         right_path_mute,
  output reg         left_biquad_select,
  output reg         right_biquad_select,
  output reg  [7:0]  left_gain,
  output reg  [7:0]  right_gain,
  output reg         coef_wr,
  output reg  [5:0]  coef_wr_index,
  output reg  [15:0] coef_wr_word
);
  // divider length, cut on purpose to the 10-bit counter; it fits
  localparam [31:0] SAMPLE_FULL   = `DOPC_SAMPLE_CYCLES;
  localparam [9:0]  SAMPLE_CYCLES = SAMPLE_FULL[9:0];
  localparam integer CHANNELS     = 2;

  // ==========================================================
  // internal state and wiring
  reg  [7:0]  left_ctrl;
  reg  [7:0]  right_ctrl;
  reg  [7:0]  gain_target_l;
  reg  [7:0]  gain_target_r;
  reg  [7:0]  coef_byte_value;
  reg  [5:0]  coef_byte_index;
  // an even and an odd byte index share one 16-bit coefficient
  reg  [15:0] coef_mem [0:`DOPC_COEF_COUNT/2-1];
  reg  [9:0]  tick_cnt;
  reg         sample_tick;
  wire [7:0]  gain_l;
  wire [7:0]  gain_r;
  wire [1:0]  ramp_bits;
  wire [1:0]  fine_bits;
  wire [15:0] target_bus;
  wire [15:0] gain_bus;
  wire        index_wr;
  wire [4:0]  word_sel;
  reg  [15:0] next_word;
  reg  [7:0]  next_rdata;

  // ==========================================================
  // sample period divider
  // the tick rounds the period down, a small rate error traded for one counter
  always @(posedge ref_clk) begin
    if (!rstn) begin
      tick_cnt    <= 10'h000;
      sample_tick <= 1'b0;
    end else if (tick_cnt == SAMPLE_CYCLES - 10'h001) begin
      tick_cnt    <= 10'h000;
      sample_tick <= 1'b1;
    end else begin
      tick_cnt    <= tick_cnt + 10'h001;
      sample_tick <= 1'b0;
    end
  end

  // ==========================================================
  // register writes; reserved low bits are never stored
  // the gain registers hold targets; the ramps decide the applied gain
  always @(posedge ref_clk) begin
    if (!rstn) begin
      left_ctrl       <= `DOPC_CTRL_RESET;
      right_ctrl      <= `DOPC_CTRL_RESET;
      gain_target_l   <= `DOPC_GAIN_RESET;
      gain_target_r   <= `DOPC_GAIN_RESET;
      coef_byte_value <= `DOPC_COEF_RESET;
      coef_byte_index <= 6'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `DOPC_LEFT_CTRL_ADDR:  left_ctrl       <= reg_wdata & `DOPC_CTRL_MASK;
        `DOPC_RIGHT_CTRL_ADDR: right_ctrl      <= reg_wdata & `DOPC_CTRL_MASK;
        `DOPC_GAIN_LEFT_ADDR:  gain_target_l   <= reg_wdata;
        `DOPC_GAIN_RIGHT_ADDR: gain_target_r   <= reg_wdata;
        `DOPC_COEF_VALUE_ADDR: coef_byte_value <= reg_wdata;
        `DOPC_COEF_INDEX_ADDR: coef_byte_index <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // coefficient commit: the index write merges the held byte
  // the odd and even index of a pair select the same stored word
  assign index_wr = reg_wr && (reg_addr == `DOPC_COEF_INDEX_ADDR);
  assign word_sel = reg_wdata[5:1];

  always @* begin
    next_word = coef_mem[word_sel];
    if (reg_wdata[0])
      next_word[15:8] = coef_byte_value;
    else
      next_word[7:0] = coef_byte_value;
  end

  // memory has no reset; software loads every coefficient it uses,
  // so the first half of a word to land shows its other byte unknown
  always @(posedge ref_clk) begin
    if (rstn && index_wr)
      coef_mem[word_sel] <= next_word;
  end

  // commit report to the filter: one pulse with the merged word
  always @(posedge ref_clk) begin
    if (!rstn) begin
      coef_wr       <= 1'b0;
      coef_wr_index <= 6'h00;
      coef_wr_word  <= 16'h0000;
    end else begin
      coef_wr <= index_wr;
      if (index_wr) begin
        coef_wr_index <= {word_sel, 1'b0};
        coef_wr_word  <= next_word;
      end
    end
  end

  // ==========================================================
  // gain ramps, one per channel; channel 0 is left, in the low bits
  assign ramp_bits  = {right_ctrl[`DOPC_RAMP_BIT], left_ctrl[`DOPC_RAMP_BIT]};
  assign fine_bits  = {right_ctrl[`DOPC_FINE_BIT], left_ctrl[`DOPC_FINE_BIT]};
  assign target_bus = {gain_target_r, gain_target_l};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      // the ramp phase stays inside; only the applied gain leaves
      dopc_gain_ramp dopc_gain_ramp_inst (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .sample_tick (sample_tick),
        .ramp_on     (ramp_bits[ch]),
        .fine_on     (fine_bits[ch]),
        .target      (target_bus[ch*8 +: 8]),
        .gain        (gain_bus[ch*8 +: 8]),
        .fine_phase  ()
      );
    end
  endgenerate

  assign gain_l = gain_bus[7:0];
  assign gain_r = gain_bus[15:8];

  // ==========================================================
  // registered path outputs, left channel; one flop so nothing glitches
  always @(posedge ref_clk) begin
    if (!rstn) begin
      left_path_enable   <= 1'b0;
      left_path_mute     <= 1'b1;
      left_biquad_select <= 1'b0;
      left_gain          <= `DOPC_GAIN_RESET;
    end else begin
      left_path_enable   <= left_ctrl[`DOPC_ENABLE_BIT];
      left_path_mute     <= left_ctrl[`DOPC_MUTE_BIT];
      left_biquad_select <= left_ctrl[`DOPC_BIQUAD_BIT];
      left_gain          <= gain_l;
    end
  end

  // registered path outputs, right channel
  always @(posedge ref_clk) begin
    if (!rstn) begin
      right_path_enable   <= 1'b0;
      right_path_mute     <= 1'b1;
      right_biquad_select <= 1'b0;
      right_gain          <= `DOPC_GAIN_RESET;
    end else begin
      right_path_enable   <= right_ctrl[`DOPC_ENABLE_BIT];
      right_path_mute     <= right_ctrl[`DOPC_MUTE_BIT];
      right_biquad_select <= right_ctrl[`DOPC_BIQUAD_BIT];
      right_gain          <= gain_r;
    end
  end

  // ==========================================================
  // read mux; reserved and unmapped bits read zero
  // a read has no side effect on any register
  always @* begin
    case (reg_addr)
      `DOPC_LEFT_CTRL_ADDR:  next_rdata = left_ctrl;
      `DOPC_RIGHT_CTRL_ADDR: next_rdata = right_ctrl;
      `DOPC_COEF_VALUE_ADDR: next_rdata = coef_byte_value;
      `DOPC_COEF_INDEX_ADDR: next_rdata = {2'h0, coef_byte_index};
      `DOPC_GAIN_LEFT_ADDR:  next_rdata = gain_l;
      `DOPC_GAIN_RIGHT_ADDR: next_rdata = gain_r;
      default:               next_rdata = 8'h00;
    endcase
  end

  // read-back, one cycle after reg_rd, then held for slow masters
  // with both strobes in one cycle the read sees the old value
  always @(posedge ref_clk) begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule // dopc_out_path
`default_nettype wire

// *** dopc_out_path_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dopc_regs.vh"
module dopc_out_path_bench;
  logic        ref_clk, rstn, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata;
  wire  [7:0]  reg_rdata, left_gain, right_gain;
  wire         left_path_enable, right_path_enable, left_path_mute, right_path_mute;
  wire         left_biquad_select, right_biquad_select, coef_wr;
  wire  [5:0]  coef_wr_index;
  wire  [15:0] coef_wr_word;
  int          fail_count = 0, tests_run = 0, cycles = 0;
  localparam int S = `DOPC_SAMPLE_CYCLES;
  dopc_out_path dopc_out_path_inst (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .left_path_enable(left_path_enable),
    .right_path_enable(right_path_enable), .left_path_mute(left_path_mute), .right_path_mute(right_path_mute),
    .left_biquad_select(left_biquad_select), .right_biquad_select(right_biquad_select), .left_gain(left_gain),
    .right_gain(right_gain), .coef_wr(coef_wr), .coef_wr_index(coef_wr_index), .coef_wr_word(coef_wr_word));
  // ==========================================================
  // access tasks; all entered and left at a falling edge; a strobe stays up
  // on exit so back-to-back calls never assign it twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // read data is valid right after the edge that takes the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask
  // idle cycles: both strobes drop before any edge passes
  task automatic ticks(input int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // clock and hang guard, the run needs about 8400 cycles
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {rstn, reg_addr, reg_wdata} = '0;
    ticks(16);
    rstn = 1'b1;
    chk1(left_path_mute, 1'b1);
    chk1(left_path_enable, 1'b0);
    rdc(8'h20, 8'h40);
    rdc(8'h21, 8'h40);
    wr(8'h20, 8'hFF);
    wr(8'h21, 8'h88);
    ticks(2);
    rdc(8'h20, 8'hF8);
    chk({left_path_enable, left_path_mute, left_biquad_select, 5'h00}, 8'hE0);
    chk({right_path_enable, right_path_mute, right_biquad_select, 5'h00}, 8'hA0);
    wr(8'h20, 8'h80);
    wr(8'h21, 8'h90);
    ticks(2);
    chk({left_path_mute, left_biquad_select, right_biquad_select, 5'h00}, 8'h00);
    wr(8'h40, 8'h10);
    wr(8'h41, 8'h02);
    ticks(2);
    chk(left_gain, 8'h10);
    chk(right_gain, 8'h02);
    // slow path: ramp then ramp with fine steps, which takes four times as long
    wr(8'h20, 8'hA0);
    wr(8'h40, 8'h14);
    wr(8'h21, 8'hB0);
    wr(8'h41, 8'h06);
    ticks(2);
    chk1(left_gain == 8'h14, 1'b0);
    ticks(6 * S);
    chk(left_gain, 8'h14);
    chk1(right_gain == 8'h06, 1'b0);
    ticks(14 * S);
    chk(right_gain, 8'h06);
    // the commit pulse stands one cycle, so it is looked at as the write returns
    wr(8'h29, 8'h34);
    wr(8'h2A, 8'h03);
    chk1(coef_wr, 1'b1);
    chk({2'b00, coef_wr_index}, 8'h02);
    chk(coef_wr_word[15:8], 8'h34);
    wr(8'h29, 8'h12);
    wr(8'h2A, 8'hC2);
    chk({2'b00, coef_wr_index}, 8'h02);
    chk(coef_wr_word[7:0], 8'h12);
    chk(coef_wr_word[15:8], 8'h34);
    rdc(8'h2A, 8'h02);
    rdc(8'h29, 8'h12);
    rdc(8'h55, 8'h00);
    conclude();
  end
endmodule // dopc_out_path_bench
`default_nettype wire

// *** dopc_out_path_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dopc_regs.vh"
// ==========================================================
// port checks for the output path registers
module dopc_out_path_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        left_path_enable,
  input wire logic        left_path_mute,
  input wire logic        right_path_mute,
  input wire logic        left_biquad_select,
  input wire logic        right_biquad_select,
  input wire logic [7:0]  left_gain,
  input wire logic        coef_wr,
  input wire logic [5:0]  coef_wr_index,
  input wire logic [15:0] coef_wr_word
);
  logic [7:0] cval;
  logic       lramp;
  wire        wl = reg_wr && reg_addr == 8'h20;
  wire        wr_r = reg_wr && reg_addr == 8'h21;
  wire        wi = reg_wr && reg_addr == 8'h2A;
  // shadows, since the ramp bit and value byte are not on the ports
  always @(posedge ref_clk) begin
    if (!rstn) begin
      cval <= 8'h00;
      lramp <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h29) cval <= reg_wdata;
      if (wl) lramp <= reg_wdata[5];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  left_enable_a: assert property (wl |-> ##2 left_path_enable == $past(reg_wdata[7], 2))
    else $error("left enable mismatch");
  right_mute_a: assert property (wr_r |-> ##2 right_path_mute == $past(reg_wdata[6], 2))
    else $error("right mute mismatch");
  left_biquad_a: assert property (wl |-> ##2 left_biquad_select == $past(reg_wdata[3], 2))
    else $error("left biquad mismatch");
  right_biquad_a: assert property (wr_r |-> ##2 right_biquad_select == $past(reg_wdata[3], 2))
    else $error("right biquad mismatch");
  reset_state_a: assert property ($rose(rstn) |-> left_path_mute && right_path_mute && !left_path_enable)
    else $error("bad state after reset");
  gain_now_a: assert property (reg_wr && reg_addr == 8'h40 && !lramp |-> ##3 left_gain == $past(reg_wdata, 3))
    else $error("gain not applied at once");
  coef_pulse_a: assert property (wi |=> coef_wr && coef_wr_index == {$past(reg_wdata[5:1]), 1'b0})
    else $error("coefficient commit missing");
  coef_cause_a: assert property (coef_wr |-> $past(wi))
    else $error("commit without index write");
  coef_high_a: assert property (wi && reg_wdata[0] |=> coef_wr_word[15:8] == cval)
    else $error("high byte wrong");
  coef_low_a: assert property (wi && !reg_wdata[0] |=> coef_wr_word[7:0] == cval)
    else $error("low byte wrong");
endmodule // dopc_out_path_chk
bind dopc_out_path dopc_out_path_chk dopc_out_path_chk_inst (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .left_path_enable(left_path_enable), .left_path_mute(left_path_mute),
  .right_path_mute(right_path_mute), .left_biquad_select(left_biquad_select), .left_gain(left_gain),
  .right_biquad_select(right_biquad_select), .coef_wr(coef_wr), .coef_wr_index(coef_wr_index),
  .coef_wr_word(coef_wr_word));
`default_nettype wire

// *** dopc_regs.vh ***
`ifndef DOPC_REGS_VH
`define DOPC_REGS_VH
// ==========================================================
// register offsets
`define DOPC_LEFT_CTRL_ADDR    8'h20
`define DOPC_RIGHT_CTRL_ADDR   8'h21
`define DOPC_COEF_VALUE_ADDR   8'h29
`define DOPC_COEF_INDEX_ADDR   8'h2A
`define DOPC_GAIN_LEFT_ADDR    8'h40
`define DOPC_GAIN_RIGHT_ADDR   8'h41
// ==========================================================
// path control field positions
`define DOPC_ENABLE_BIT        7
`define DOPC_MUTE_BIT          6
`define DOPC_RAMP_BIT          5
`define DOPC_FINE_BIT          4
`define DOPC_BIQUAD_BIT        3
`define DOPC_CTRL_MASK         8'hF8
// ==========================================================
// reset values
`define DOPC_CTRL_RESET        8'h40
`define DOPC_COEF_RESET        8'h00
`define DOPC_GAIN_RESET        8'h00
// ==========================================================
// timing: one audio sample period at 48 kHz from 20 MHz
`define DOPC_SAMPLE_RATE_HZ    48000
`define DOPC_CLK_HZ            20000000
`define DOPC_SAMPLE_CYCLES     (`DOPC_CLK_HZ / `DOPC_SAMPLE_RATE_HZ)
`define DOPC_FINE_SUBSTEPS     4
`define DOPC_COEF_COUNT        64
`endif
